// *** common/mdc_pkg.sv ***
// muldiv_unit shared constants, operation codes and state layout
// assumes a single clock domain and a byte-wide register port
package mdc_pkg;

  // ----------------------------------------------------------------
  // register indices on the register port
  // ----------------------------------------------------------------
  localparam logic [2:0] ADR_OPND0 = 3'h0;
  localparam logic [2:0] ADR_OPND1 = 3'h1;
  localparam logic [2:0] ADR_OPND2 = 3'h2;
  localparam logic [2:0] ADR_OPND3 = 3'h3;
  localparam logic [2:0] ADR_OPND4 = 3'h4;
  localparam logic [2:0] ADR_OPND5 = 3'h5;
  localparam logic [2:0] ADR_CTRL = 3'h6;
  localparam int OPND_BYTES = 6;

  // ----------------------------------------------------------------
  // arith_control_reg layout
  // ----------------------------------------------------------------
  localparam int CTRL_ERR_BIT = 7;
  localparam int CTRL_OVF_BIT = 6;
  localparam int CTRL_DIR_BIT = 5;
  localparam logic [4:0] COUNT_ZERO = 5'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // execution times in clock cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] CYC_DIV32 = 5'h11;
  localparam logic [4:0] CYC_DIV16 = 5'h09;
  localparam logic [4:0] CYC_MUL = 5'h0B;
  localparam logic [4:0] CYC_SHIFT_BASE = 5'h02;
  localparam logic [4:0] CYC_NORM_BASE = 5'h03;
  localparam logic [4:0] CYC_NORM_MIN = 5'h04;
  localparam logic [4:0] CYC_START_USED = 5'h02;
  localparam logic [4:0] CNT_STEP = 5'h01;

  // ----------------------------------------------------------------
  // arithmetic limits
  // ----------------------------------------------------------------
  localparam logic [31:0] MUL_OVF_LIMIT = 32'h0000_FFFF;
  localparam logic [31:0] QUOT_DIVZERO = 32'hFFFF_FFFF;
  localparam logic [15:0] HALF_ZERO = 16'h0000;
  localparam logic [5:0] NORM_MAX_SHIFT = 6'h1F;

  typedef enum logic [2:0] {
    OP_DIV32,
    OP_DIV16,
    OP_MUL,
    OP_SHIFT,
    OP_NORM
  } mdc_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_CALC,
    ST_READ
  } mdc_phase_t;

  typedef struct packed {
    mdc_op_t op;
    logic [47:0] opnd;
    logic dir;
    logic [4:0] count;
  } mdc_req_t;

  typedef struct packed {
    logic [47:0] data;
    logic ovf;
    logic [4:0] cyc;
    logic [4:0] normCount;
  } mdc_res_t;

  typedef struct packed {
    mdc_phase_t phase;
    mdc_op_t op;
    logic [47:0] opnd;
    logic dir;
    logic [4:0] count;
    logic err;
    logic ovf;
    logic first;
    logic [4:0] cnt;
    logic sawWide;
    logic sawMul;
    logic [7:0] rdData;
    logic busy;
  } mdc_state_t;

  localparam mdc_state_t STATE_RST = '{
    phase: ST_IDLE,
    op: OP_DIV32,
    opnd: 48'h0000_0000_0000,
    dir: 1'b0,
    count: 5'h00,
    err: 1'b0,
    ovf: 1'b0,
    first: 1'b0,
    cnt: 5'h00,
    sawWide: 1'b0,
    sawMul: 1'b0,
    rdData: 8'h00,
    busy: 1'b0
  };

endpackage

// *** core/mdc_arith.sv ***
// muldiv_unit arithmetic: result, overflow and run time of one operation
// assumes operands stay stable while a calculation runs
`timescale 1ns/1ns
module mdc_arith
  import mdc_pkg::*;
(
  input wire mdc_req_t req,
  output mdc_res_t res
);

  logic [31:0] num32;
  logic [15:0] num16;
  logic [15:0] divisor;
  logic [31:0] prod;
  logic [31:0] shifted;
  logic [5:0] lz;
  logic found;
  logic [5:0] half;

  always_comb begin
    num32 = req.opnd[31:0];
    num16 = req.opnd[15:0];
    divisor = req.opnd[47:32];
    prod = 32'(num16) * 32'(divisor);
    // --------------------------------------------------------------
    // leading zero count for normalize
    // --------------------------------------------------------------
    lz = 6'h00;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found) begin
        if (num32[i]) begin
          found = 1'b1;
        end else begin
          lz = 6'(lz + 6'h01);
        end
      end
    end
    if (lz > NORM_MAX_SHIFT) begin
      lz = NORM_MAX_SHIFT;
    end
    half = 6'(({1'b0, req.count} + 6'h01) >> 1);
    res.data = req.opnd;
    res.ovf = 1'b0;
    res.cyc = CYC_DIV32;
    res.normCount = req.count;
    shifted = req.dir ? (num32 >> req.count) : (num32 << req.count);
    case (req.op)
      OP_DIV32: begin
        res.ovf = (divisor == HALF_ZERO);
        if (res.ovf) begin
          res.data = {num16, QUOT_DIVZERO};
        end else begin
          res.data = {16'(num32 % divisor), num32 / divisor};
        end
        res.cyc = CYC_DIV32;
      end
      OP_DIV16: begin
        res.ovf = (divisor == HALF_ZERO);
        if (res.ovf) begin
          res.data = {num16, req.opnd[31:16], QUOT_DIVZERO[15:0]};
        end else begin
          res.data = {num16 % divisor, req.opnd[31:16], num16 / divisor};
        end
        res.cyc = CYC_DIV16;
      end
      OP_MUL: begin
        res.data = {divisor, prod};
        res.ovf = (prod > MUL_OVF_LIMIT);
        res.cyc = CYC_MUL;
      end
      OP_SHIFT: begin
        res.data = {divisor, shifted};
        res.cyc = 5'(CYC_SHIFT_BASE + half[4:0]);
      end
      default: begin
        res.data = {divisor, 32'(num32 << lz)};
        res.ovf = num32[31];
        res.normCount = lz[4:0];
        half = 6'((lz + 6'h01) >> 1);
        res.cyc = 5'(CYC_NORM_BASE + half[4:0]);
        if (res.cyc < CYC_NORM_MIN) begin
          res.cyc = CYC_NORM_MIN;
        end
      end
    endcase
  end

endmodule

// *** core/mdc_top.sv ***
// muldiv_unit top: register port, load sequencing, timing and error flags
// assumes the processor drives the register port from the same clock
//
// Notes on behaviour
// - final loading write starts the selected calculation
// - bytes two or three written select long division
// - byte four selects short divide, byte one multiply
// - zero shift count selects normalize, else shift
// - calculation runs without stalling the processor
// - divides take 17 or 9, multiply 11 cycles
// - shift takes 3 to 18 cycles by count
// - normalize takes 4 to 19 cycles
// - last result read ends the calculation
// - normalize shifts left until top bit set
// - normalize stores shift count in control field
// - shift by low control bits, nonzero count
// - direction bit zero left, one right
// - vacated bit positions fill with zeros
// - checking armed by starting write, off when result is stored
// - write during calculation sets error; final-byte or control write restarts, other byte writes return to loading
// - operand read during calculation sets error, keeps running
// - error flag read-only, cleared by control read
// - overflow on zero divisor, big product, normalize with top bit set
// - other calculations clear overflow
// - overflow flag not writable by software
// - overflow visible at control bit six
`timescale 1ns/1ns
module mdc_top
  import mdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic calcBusy
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe;
  logic rstSync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSync_n = rstPipe[1];

  // ----------------------------------------------------------------
  // state and arithmetic
  // ----------------------------------------------------------------
  mdc_state_t st;
  mdc_state_t next_st;
  mdc_req_t req;
  mdc_res_t res;
  logic startMulDiv;
  logic startShift;
  logic inCalc;
  logic isDivOp;
  logic [2:0] lastAddr;

  assign req = '{op: st.op, opnd: st.opnd, dir: st.dir, count: st.count};

  mdc_arith u_arith (
    .req(req),
    .res(res)
  );

  assign inCalc = (st.phase == ST_CALC);
  assign isDivOp = (st.op == OP_DIV32) || (st.op == OP_DIV16);
  assign lastAddr = isDivOp ? ADR_OPND5 : ADR_OPND3;

  always_comb begin
    next_st = st;
    next_st.rdData = BYTE_ZERO;
    startMulDiv = 1'b0;
    startShift = 1'b0;

    // --------------------------------------------------------------
    // calculation timing
    // --------------------------------------------------------------
    if (inCalc) begin
      if (st.first) begin
        next_st.first = 1'b0;
        next_st.cnt = 5'(res.cyc - CYC_START_USED);
      end else if (st.cnt == COUNT_ZERO) begin
        next_st.opnd = res.data;
        next_st.ovf = res.ovf;
        if (st.op == OP_NORM) begin
          next_st.count = res.normCount;
        end
        next_st.phase = ST_READ;
      end else begin
        next_st.cnt = 5'(st.cnt - CNT_STEP);
      end
    end

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    if (regWr) begin
      if (regAddr == ADR_CTRL) begin
        next_st.dir = regWrData[CTRL_DIR_BIT];
        next_st.count = regWrData[4:0];
        if (inCalc) begin
          next_st.err = 1'b1;
        end
        if (st.phase == ST_LOAD || inCalc) begin
          startShift = 1'b1;
        end
      end else if (regAddr <= ADR_OPND5) begin
        next_st.opnd[8 * int'(regAddr) +: 8] = regWrData;
        if (inCalc) begin
          next_st.err = 1'b1;
          next_st.phase = ST_LOAD;
          next_st.first = 1'b0;
        end
        if (regAddr == ADR_OPND0) begin
          next_st.phase = ST_LOAD;
          next_st.sawWide = 1'b0;
          next_st.sawMul = 1'b0;
        end else if (st.phase == ST_LOAD || inCalc) begin
          if (regAddr == ADR_OPND2 || regAddr == ADR_OPND3) begin
            next_st.sawWide = 1'b1;
          end else if (regAddr == ADR_OPND1) begin
            next_st.sawMul = 1'b1;
          end else if (regAddr == ADR_OPND4) begin
            next_st.sawMul = 1'b0;
          end else if (regAddr == ADR_OPND5) begin
            startMulDiv = 1'b1;
          end
        end
      end
    end

    // --------------------------------------------------------------
    // operation selection and start
    // --------------------------------------------------------------
    if (startMulDiv) begin
      if (next_st.sawWide) begin
        next_st.op = OP_DIV32;
      end else if (next_st.sawMul) begin
        next_st.op = OP_MUL;
      end else begin
        next_st.op = OP_DIV16;
      end
    end
    if (startShift) begin
      if (regWrData[4:0] == COUNT_ZERO) begin
        next_st.op = OP_NORM;
      end else begin
        next_st.op = OP_SHIFT;
      end
    end
    if (startMulDiv || startShift) begin
      next_st.phase = ST_CALC;
      next_st.first = 1'b1;
      next_st.cnt = COUNT_ZERO;
    end

    // --------------------------------------------------------------
    // register reads
    // --------------------------------------------------------------
    if (regRd) begin
      if (regAddr == ADR_CTRL) begin
        next_st.rdData[CTRL_ERR_BIT] = st.err;
        next_st.rdData[CTRL_OVF_BIT] = st.ovf;
        next_st.rdData[CTRL_DIR_BIT] = st.dir;
        next_st.rdData[4:0] = st.count;
        next_st.err = 1'b0;
      end else if (regAddr <= ADR_OPND5) begin
        next_st.rdData = st.opnd[8 * int'(regAddr) +: 8];
        if (inCalc) begin
          next_st.err = 1'b1;
        end
        if (st.phase == ST_READ && regAddr == lastAddr) begin
          next_st.phase = ST_IDLE;
        end
      end else begin
        next_st.rdData = BYTE_ZERO;
      end
    end

    next_st.busy = (next_st.phase == ST_CALC);
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData = st.rdData;
  assign calcBusy = st.busy;

endmodule

// *** testbench/mdc_top_sva.sv ***
// port checker for mdc_top
// assumes the bind below attaches it to every mdc_top
`timescale 1ns/1ns
module mdc_top_sva
  import mdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic calcBusy
);
  // ------------------------------
  // helpers
  // ------------------------------
  logic [4:0] busyCnt;
  logic [2:0] prevWr;
  logic wide;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt <= 5'h00;
      prevWr <= 3'h0;
      wide <= 1'b0;
    end else begin
      busyCnt <= (calcBusy && !regWr) ? busyCnt + 5'h01 : 5'h00;
      if (regWr) begin
        prevWr <= regAddr;
        wide <= regAddr == ADR_OPND2 || regAddr == ADR_OPND3 ||
          (wide && regAddr != ADR_OPND0);
      end
    end
  end
  // ------------------------------
  // assertions
  // ------------------------------
  a_start_write: assert property (
    $rose(calcBusy) |-> $past(regWr) &&
      ($past(regAddr) == ADR_OPND5 || $past(regAddr) == ADR_CTRL))
    else $error("busy rose without final write");
  a_busy_bound: assert property (
    calcBusy |-> busyCnt < 5'h13)
    else $error("calculation too long");
  a_busy_min: assert property (
    $rose(calcBusy) |-> (calcBusy || $past(regWr))[*3])
    else $error("calculation too short");
  a_read_runs: assert property (
    calcBusy && regRd && busyCnt < 5'h02 |=> calcBusy)
    else $error("read stopped calculation");
  a_rd_quiet: assert property (
    !$past(regRd) |-> regRdData == BYTE_ZERO)
    else $error("read data without read");
  a_err_clear: assert property (
    regRd && regAddr == ADR_CTRL && !calcBusy ##1 (!regRd && !regWr)[*2]
      ##1 regRd && regAddr == ADR_CTRL && !calcBusy
      |=> !regRdData[CTRL_ERR_BIT])
    else $error("error flag not cleared by read");
  a_mul_time: assert property (
    regWr && regAddr == ADR_OPND5 && prevWr == ADR_OPND1 && !wide &&
      !calcBusy |=> calcBusy[*8] ##1 calcBusy[*3] ##1 !calcBusy)
    else $error("multiply time wrong");
  a_div16_time: assert property (
    regWr && regAddr == ADR_OPND5 && prevWr == ADR_OPND4 && !wide &&
      !calcBusy |=> calcBusy[*8] ##1 calcBusy ##1 !calcBusy)
    else $error("short divide time wrong");
  a_div32_time: assert property (
    regWr && regAddr == ADR_OPND5 && wide && !calcBusy
      |=> calcBusy[*8] ##1 calcBusy[*8] ##1 calcBusy ##1 !calcBusy)
    else $error("long divide time wrong");
endmodule
bind mdc_top mdc_top_sva chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .calcBusy(calcBusy));

// *** testbench/mdc_cpu_model.sv ***
// processor model driving the register port
// assumes the same clock as mdc_top
`timescale 1ns/1ns
module mdc_cpu_model
  import mdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] regRdData,
  output logic [2:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWr,
  output logic regRd
);
  initial begin
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // ------------------------------
  // bus cycles
  // ------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    @(posedge sys_clk);
    d = regRdData;
  endtask
  // ------------------------------
  // operation sequences
  // ------------------------------
  task automatic load(input logic [1:0] k, input logic [47:0] v,
    input logic [7:0] c);
    wr(ADR_OPND0, v[7:0]);
    if (k == 2'h2) begin
      wr(ADR_OPND4, v[39:32]);
      wr(ADR_OPND1, v[15:8]);
    end else if (k == 2'h1) begin
      wr(ADR_OPND1, v[15:8]);
      wr(ADR_OPND4, v[39:32]);
    end else begin
      for (int i = 1; i < 4; i++) begin
        wr(3'(i), v[8*i +: 8]);
      end
    end
    if (k == 2'h3) begin
      wr(ADR_CTRL, c);
    end else begin
      if (k == 2'h0) begin
        wr(ADR_OPND4, v[39:32]);
      end
      wr(ADR_OPND5, v[47:40]);
    end
  endtask
  task automatic unload(input logic [1:0] k, output logic [47:0] r);
    logic [7:0] b;
    int a;
    for (int i = 0; i < 6; i++) begin
      a = (k < 2'h2) ? i : (i + 4) % 6;
      rd(3'(a), b);
      r[8*a +: 8] = b;
    end
  endtask
endmodule

// *** testbench/test_mdc_top.sv ***
// self-checking bench for mdc_top
// assumes mdc_cpu_model drives the register port
`timescale 1ns/1ns
module test_mdc_top
  import mdc_pkg::*;
();
  typedef struct {
    logic [1:0] k;
    logic [47:0] v;
    logic [7:0] c;
    logic [7:0] cyc;
    logic [47:0] r;
    logic [7:0] ctl;
  } mdc_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic calcBusy;
  int mismatches = 0;
  int checked = 0;
  int n;
  logic [47:0] r;
  logic [7:0] b;
  mdc_row_t rows [9];
  always #10 sys_clk = ~sys_clk;
  mdc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .calcBusy(calcBusy));
  mdc_cpu_model cpu (.sys_clk(sys_clk), .regRdData(regRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd));
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic check(input string nm, input logic [47:0] s,
    input logic [47:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic settle();
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (calcBusy === 1'b1 && n < 40);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    rows = '{
      '{2'h0, 48'h0003_0001_0000, 8'h00, 8'h11, 48'h0001_0000_5555, 8'h00},
      '{2'h1, 48'h0010_0000_1234, 8'h00, 8'h09, 48'h0004_0000_0123, 8'h00},
      '{2'h1, 48'h0000_0000_0055, 8'h00, 8'h09, 48'h0055_0000_FFFF, 8'h40},
      '{2'h2, 48'h0100_0000_0100, 8'h00, 8'h0B, 48'h0100_0001_0000, 8'h40},
      '{2'h2, 48'h0101_0000_00FF, 8'h00, 8'h0B, 48'h0101_0000_FFFF, 8'h00},
      '{2'h3, 48'h0000_8000_0001, 8'h01, 8'h03, 48'h0101_0000_0002, 8'h01},
      '{2'h3, 48'h0000_8000_0000, 8'h3F, 8'h12, 48'h0101_0000_0001, 8'h3F},
      '{2'h3, 48'h0000_0000_0001, 8'h00, 8'h13, 48'h0101_8000_0000, 8'h1F},
      '{2'h3, 48'h0000_8000_0000, 8'h00, 8'h04, 48'h0101_8000_0000, 8'h40}};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cpu.rd(ADR_CTRL, b);
    check("ctrl reset", b, 8'h00);
    cpu.wr(3'h7, 8'hFF);
    cpu.rd(3'h7, b);
    check("unmapped", b, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      cpu.load(rows[i].k, rows[i].v, rows[i].c);
      settle();
      check("cycles", 48'(n - 1), rows[i].cyc);
      cpu.unload(rows[i].k, r);
      check("result", r, rows[i].r);
      cpu.rd(ADR_CTRL, b);
      check("ctrl", b, rows[i].ctl);
      $display("test row %0d done", i);
    end
    cpu.load(rows[4].k, rows[4].v, rows[4].c);
    cpu.rd(ADR_OPND0, b);
    settle();
    cpu.unload(rows[4].k, r);
    check("read in run", r, rows[4].r);
    cpu.rd(ADR_CTRL, b);
    check("err set", b, 8'h80);
    cpu.rd(ADR_CTRL, b);
    check("err clear", b, 8'h00);
    cpu.rd(ADR_OPND0, b);
    cpu.rd(ADR_CTRL, b);
    check("disarmed", b, 8'h00);
    $display("test early read done");
    cpu.load(rows[6].k, rows[6].v, rows[6].c);
    cpu.wr(ADR_CTRL, 8'h21);
    settle();
    cpu.unload(2'h3, r);
    check("restart data", r, 48'h0101_4000_0000);
    cpu.rd(ADR_CTRL, b);
    check("restart", b, 8'hA1);
    $display("test restart done");
    cpu.load(rows[8].k, rows[8].v, rows[8].c);
    settle();
    cpu.unload(2'h3, r);
    cpu.wr(ADR_CTRL, 8'h00);
    cpu.rd(ADR_CTRL, b);
    check("ovf kept", b, 8'h40);
    $display("test overflow write done");
    print_verdict();
  end
endmodule
